// file: inc/plt_pkg.sv
// Purpose: shared constants for the position list trigger engine
// Assumes: 125 MHz aclk, AXI4-Lite register access with 32-bit data
// Notes: entry memories are windowed per list through an index register
package plt_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  // trigger spacing, in microseconds as printed (3 ms)
  localparam int unsigned TRIG_SPACING_US = 3000;
  localparam int unsigned TRIG_SPACING_CYC = (CLK_HZ / 1000000) * TRIG_SPACING_US;
  localparam int unsigned ENTRIES = 64;
  localparam int unsigned IDX_W = 6;
  // list kind encodings and register reset values
  localparam logic [15:0] KIND_SIGNAL = 16'h0001;
  localparam logic [15:0] KIND_SPEED = 16'h0002;
  localparam logic [15:0] KIND_RESET = 16'h0001;
  localparam logic [15:0] IDLE_LEVEL_RESET = 16'h0000;
  localparam logic [5:0] START_RESET = 6'h00;
  localparam logic [5:0] FINISH_RESET = 6'h3F;
  // motion modes seen on the mode input
  localparam logic [1:0] MODE_OTHER = 2'h0;
  localparam logic [1:0] MODE_PTP = 2'h1;
  localparam logic [1:0] MODE_VEL = 2'h2;
  // register byte addresses and bus response codes
  localparam logic [7:0] A_ACTIVE = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_IDLE = 8'h08;
  localparam logic [7:0] A_MAXSPD = 8'h0C;
  localparam logic [7:0] A_START1 = 8'h10;
  localparam logic [7:0] A_FINISH1 = 8'h14;
  localparam logic [7:0] A_START2 = 8'h18;
  localparam logic [7:0] A_FINISH2 = 8'h1C;
  localparam logic [7:0] A_KIND1 = 8'h20;
  localparam logic [7:0] A_KIND2 = 8'h24;
  localparam logic [7:0] A_EIDX = 8'h28;
  localparam logic [7:0] A_POS1 = 8'h30;
  localparam logic [7:0] A_SIG1 = 8'h34;
  localparam logic [7:0] A_SPD1 = 8'h38;
  localparam logic [7:0] A_POS2 = 8'h40;
  localparam logic [7:0] A_SIG2 = 8'h44;
  localparam logic [7:0] A_SPD2 = 8'h48;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: hw/plt_spacing.sv
// Purpose: minimum trigger spacing gate
// Assumes: one clock, same-domain request pulses
// Notes: a held request is released once the spacing has run out; only clear or reset drops it
module plt_spacing #(
  parameter int unsigned SPACING_CYC = plt_pkg::TRIG_SPACING_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // request and release
  input wire logic clear,
  input wire logic request,
  output logic fire
);
  import plt_pkg::*;
  logic [31:0] gap_count;
  logic pending;

  // a request waits while the previous event is closer than the spacing, except one arriving while fire is still high
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      pending <= 1'b0;
      fire <= 1'b0;
    end else begin
      fire <= 1'b0;
      if ((request || pending) && gap_count == 32'h0) begin
        fire <= 1'b1;
        pending <= 1'b0;
      end else if (request) begin
        pending <= 1'b1;
      end
    end
  end

  // spacing counter restarts on every release
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      gap_count <= 32'h0;
    end else if (fire) begin
      gap_count <= 32'(SPACING_CYC - 2);
    end else if (gap_count != 32'h0) begin
      gap_count <= gap_count - 32'h1;
    end
  end
endmodule

// file: hw/plt_top.sv
// Purpose: position-compare list engine with trigger output and speed setpoint
// Assumes: positions in user units, compared each cycle against live inputs
// Notes: registers over AXI4-Lite; entry fields reached through an index window
// Notes on behaviour
// - each list has one kind: 1 signal lists, 2 speed lists; resets to 1
// - each entry keeps a signal level 0 or 1, in 16 bits, reset zero
// - entry speed signed 32-bit, clipped to max speed; mode fallbacks on zero/nonzero
// - signal list: trigger takes entry level when entry position equals measured position
// - closer triggers are delayed until spacing passes (not a match one cycle after a release here); a further match while one is held replaces the held level
// - trigger switches within a few cycles of the exact match
// - ramps may shift trigger slightly; exact compare keeps shift minimal
// - idle level driven at list start and after interruption
// - speed list: setpoint takes entry speed when entry equals commanded position
// - entries hold signed 32-bit positions, reset zero, 64 per list
// - entries processed ascending from start index toward finish index
// - after finish entry, list stops; indices and entries stay as they are
//
// The AXI4-Lite slave port and the register addresses were decided locally.
module plt_top #(
  parameter int unsigned SPACING_CYC = plt_pkg::TRIG_SPACING_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // motion side
  input wire logic [1:0] motion_mode,
  input wire logic signed [31:0] measured_position,
  input wire logic signed [31:0] commanded_position,
  input wire logic signed [31:0] point_move_target_speed,
  input wire logic signed [31:0] velocity_mode_speed,
  // list outputs
  output logic trigger_out,
  output logic signed [31:0] speed_setpoint,
  output logic speed_update
);
  import plt_pkg::*;

  typedef enum logic [1:0] {PLT_IDLE, PLT_RUN, PLT_DONE} plt_state_e;

  // entry storage, one array per field, indexed by list
  logic signed [31:0] pos_mem [2][ENTRIES];
  logic sig_mem [2][ENTRIES];
  logic signed [31:0] spd_mem [2][ENTRIES];

  // software registers
  logic [1:0] active_list_select;
  logic [15:0] idle_trigger_level;
  logic signed [31:0] maximum_motor_speed;
  logic [5:0] start_index [2];
  logic [5:0] finish_index [2];
  logic [15:0] list_kind [2];
  logic [5:0] entry_index;

  // engine state
  plt_state_e state;
  logic [5:0] pointer;
  logic list_sel;
  logic done_flag;

  // bus handshake state
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic [31:0] wmask;
  logic [31:0] next_rdata;
  logic next_rok;

  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

  // write address and data are taken independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_awvalid ? 1'b1 : !aw_held && !s_axi_awready;
      s_axi_wready <= !w_held && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  // write response follows both halves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr[1:0] == 2'h0 && aw_addr <= A_SPD2) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control registers written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_trigger_level <= IDLE_LEVEL_RESET;
      maximum_motor_speed <= 32'sh7FFFFFFF;
      start_index[0] <= START_RESET;
      start_index[1] <= START_RESET;
      finish_index[0] <= FINISH_RESET;
      finish_index[1] <= FINISH_RESET;
      list_kind[0] <= KIND_RESET;
      list_kind[1] <= KIND_RESET;
      entry_index <= 6'h00;
    end else if (wr_go) begin
      case (aw_addr)
        A_IDLE: idle_trigger_level <= {15'h0, w_data[0]};
        A_MAXSPD: maximum_motor_speed <= (maximum_motor_speed & ~wmask) | (w_data & wmask);
        A_START1: start_index[0] <= w_data[5:0];
        A_FINISH1: finish_index[0] <= w_data[5:0];
        A_START2: start_index[1] <= w_data[5:0];
        A_FINISH2: finish_index[1] <= w_data[5:0];
        A_KIND1: if (w_data[15:0] == KIND_SIGNAL || w_data[15:0] == KIND_SPEED) list_kind[0] <= w_data[15:0];
        A_KIND2: if (w_data[15:0] == KIND_SIGNAL || w_data[15:0] == KIND_SPEED) list_kind[1] <= w_data[15:0];
        A_EIDX: entry_index <= w_data[5:0];
        default: ;
      endcase
    end
  end

  // entry memories, reset to zero and reached through the entry index
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int l = 0; l < 2; l++) begin
        for (int e = 0; e < ENTRIES; e++) begin
          pos_mem[l][e] <= 32'sh0;
          sig_mem[l][e] <= 1'b0;
          spd_mem[l][e] <= 32'sh0;
        end
      end
    end else if (wr_go) begin
      case (aw_addr)
        A_POS1: pos_mem[0][entry_index] <= (pos_mem[0][entry_index] & ~wmask) | (w_data & wmask);
        A_POS2: pos_mem[1][entry_index] <= (pos_mem[1][entry_index] & ~wmask) | (w_data & wmask);
        A_SIG1: if (w_data[15:1] == 15'h0) sig_mem[0][entry_index] <= w_data[0];
        A_SIG2: if (w_data[15:1] == 15'h0) sig_mem[1][entry_index] <= w_data[0];
        A_SPD1: spd_mem[0][entry_index] <= clip_speed(w_data);
        A_SPD2: spd_mem[1][entry_index] <= clip_speed(w_data);
        default: ;
      endcase
    end
  end

  // limit a speed to plus or minus the maximum motor speed
  function automatic logic signed [31:0] clip_speed(input logic signed [31:0] v);
    logic signed [31:0] lim;
    lim = maximum_motor_speed;
    if (v > lim) clip_speed = lim;
    else if (v < -lim) clip_speed = -lim;
    else clip_speed = v;
  endfunction

  // active list select; writing 1 or 2 starts a fresh run, 0 or 3 interrupts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_list_select <= 2'h0;
    end else if (wr_go && aw_addr == A_ACTIVE) begin
      active_list_select <= (w_data[1:0] == 2'h3) ? 2'h0 : w_data[1:0];
    end
  end

  // read data path
  always_comb begin
    next_rok = 1'b1;
    next_rdata = 32'h0;
    case (s_axi_araddr)
      A_ACTIVE: next_rdata = {30'h0, active_list_select};
      A_STATUS: next_rdata = {16'h0, 1'b0, done_flag, 6'h0, pointer, (state == PLT_RUN), list_sel};
      A_IDLE: next_rdata = {16'h0, idle_trigger_level};
      A_MAXSPD: next_rdata = maximum_motor_speed;
      A_START1: next_rdata = {26'h0, start_index[0]};
      A_FINISH1: next_rdata = {26'h0, finish_index[0]};
      A_START2: next_rdata = {26'h0, start_index[1]};
      A_FINISH2: next_rdata = {26'h0, finish_index[1]};
      A_KIND1: next_rdata = {16'h0, list_kind[0]};
      A_KIND2: next_rdata = {16'h0, list_kind[1]};
      A_EIDX: next_rdata = {26'h0, entry_index};
      A_POS1: next_rdata = pos_mem[0][entry_index];
      A_SIG1: next_rdata = {31'h0, sig_mem[0][entry_index]};
      A_SPD1: next_rdata = spd_mem[0][entry_index];
      A_POS2: next_rdata = pos_mem[1][entry_index];
      A_SIG2: next_rdata = {31'h0, sig_mem[1][entry_index]};
      A_SPD2: next_rdata = spd_mem[1][entry_index];
      default: next_rok = 1'b0;
    endcase
  end

  // read channel: one read at a time, answer one cycle after acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // engine control signals
  logic start_pulse;
  logic stop_pulse;
  logic is_speed_list;
  logic signed [31:0] cur_pos;
  logic signed [31:0] cur_spd;
  logic cur_sig;
  logic match;
  logic trig_fire;
  logic trig_level_held;
  logic last_entry;

  assign start_pulse = wr_go && aw_addr == A_ACTIVE && (w_data[1:0] == 2'h1 || w_data[1:0] == 2'h2);
  assign stop_pulse = wr_go && aw_addr == A_ACTIVE && !start_pulse;
  assign is_speed_list = list_kind[list_sel] == KIND_SPEED;
  assign cur_pos = pos_mem[list_sel][pointer];
  assign cur_spd = spd_mem[list_sel][pointer];
  assign cur_sig = sig_mem[list_sel][pointer];
  assign last_entry = pointer == finish_index[list_sel];
  // signal lists watch the pick-up, speed lists the set position; exact match keeps ramp shift small
  assign match = state == PLT_RUN &&
    (is_speed_list ? cur_pos == commanded_position : cur_pos == measured_position);

  // walk the pending entry from start toward finish
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= PLT_IDLE;
      pointer <= START_RESET;
      list_sel <= 1'b0;
      done_flag <= 1'b0;
    end else if (start_pulse) begin
      state <= PLT_RUN;
      list_sel <= w_data[1];
      pointer <= start_index[w_data[1]];
      done_flag <= 1'b0;
    end else if (stop_pulse) begin
      state <= PLT_IDLE;
    end else begin
      case (state)
        PLT_RUN: begin
          if (match && last_entry) begin
            state <= PLT_DONE;
            done_flag <= 1'b1;
          end else if (match) begin
            pointer <= pointer + 6'h1;
          end
        end
        PLT_DONE: ;
        PLT_IDLE: ;
        default: state <= PLT_IDLE;
      endcase
    end
  end

  // spacing gate between successive trigger changes
  plt_spacing #(
    .SPACING_CYC(SPACING_CYC)
  ) u_spacing (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(start_pulse || stop_pulse),
    .request(match && !is_speed_list),
    .fire(trig_fire)
  );

  // level to apply once the gate releases
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_level_held <= 1'b0;
    end else if (match && !is_speed_list) begin
      trig_level_held <= cur_sig;
    end
  end

  // trigger output: idle level on start or interruption, entry level on release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trigger_out <= 1'b0;
    end else if (start_pulse || stop_pulse) begin
      trigger_out <= idle_trigger_level[0];
    end else if (trig_fire) begin
      trigger_out <= trig_level_held;
    end
  end

  // speed setpoint with mode-dependent fallback
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_setpoint <= 32'sh0;
      speed_update <= 1'b0;
    end else begin
      speed_update <= 1'b0;
      if (match && is_speed_list) begin
        speed_update <= 1'b1;
        if (motion_mode == MODE_PTP && cur_spd == 32'sh0) speed_setpoint <= point_move_target_speed;
        else if (motion_mode == MODE_VEL && cur_spd != 32'sh0) speed_setpoint <= velocity_mode_speed;
        else speed_setpoint <= cur_spd;
      end
    end
  end
endmodule

// file: bench/plt_top_checker.sv
// Purpose: port-level checks of the list trigger engine
// Assumes: one clock, synchronous active-low reset
// Notes: bound into plt_top, sees its ports only
module plt_top_checker #(
  parameter int unsigned SPACING_CYC = plt_pkg::TRIG_SPACING_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // list outputs
  input wire logic trigger_out,
  input wire logic signed [31:0] speed_setpoint,
  input wire logic speed_update
);
  timeunit 1ns;
  timeprecision 1ps;
  import plt_pkg::*;
  logic wr_hs;
  logic ar_hs;
  logic idle_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // bus handshakes
  assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  // shadow of the idle trigger level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_q <= 1'b0;
    end else if (wr_hs && s_axi_awaddr == A_IDLE) begin
      idle_q <= s_axi_wdata[0];
    end
  end
  update_pulse_a: assert property (speed_update |=> !speed_update)
    else $error("speed update pulse too long");
  setpoint_cause_a: assert property ($changed(speed_setpoint) |-> speed_update)
    else $error("setpoint moved without update");
  idle_level_a: assert property (wr_hs && s_axi_awaddr == A_ACTIVE |-> ##[1:3] trigger_out == idle_q)
    else $error("trigger not at idle level");
  write_answer_a: assert property (wr_hs |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  read_answer_a: assert property (ar_hs |=> s_axi_rvalid)
    else $error("read data missing");
  bresp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  rresp_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  slverr_data_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  cover property (speed_update);
  cover property ($fell(trigger_out));
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule

bind plt_top plt_top_checker #(.SPACING_CYC(SPACING_CYC)) plt_top_checker_inst (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .trigger_out, .speed_setpoint, .speed_update);

// file: bench/plt_motion_model.sv
// Purpose: profile generator and pick-up feedback stand-in
// Assumes: one unit of travel per cycle
// Notes: pick-up lags the set position by one cycle
module plt_motion_model #(
  parameter logic signed [31:0] TGT_SPEED = 32'h0000_0258,
  parameter logic signed [31:0] VEL_SPEED = 32'h0000_0190
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // travel request
  input wire logic signed [31:0] goal,
  // feedback
  output logic signed [31:0] measured_position,
  output logic signed [31:0] commanded_position,
  output logic signed [31:0] point_move_target_speed,
  output logic signed [31:0] velocity_mode_speed
);
  timeunit 1ns;
  timeprecision 1ps;
  // fallback speeds of the two modes
  assign point_move_target_speed = TGT_SPEED;
  assign velocity_mode_speed = VEL_SPEED;
  // set position walks toward the goal
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      commanded_position <= '0;
      measured_position <= '0;
    end else begin
      if (commanded_position < goal) commanded_position <= commanded_position + 1;
      else if (commanded_position > goal) commanded_position <= commanded_position - 1;
      measured_position <= commanded_position;
    end
  end
endmodule

// file: bench/plt_top_tb.sv
// Purpose: self-checking bench for the list trigger engine
// Assumes: spacing shortened to SP cycles
// Notes: registers reached through axi4-lite tasks
module plt_top_tb
  import plt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SP = 20;
  localparam logic [31:0] TGT = 32'h258;
  localparam logic [31:0] VSP = 32'h190;
  localparam logic [7:0] RA [11] = '{A_KIND1, A_KIND2, A_IDLE, A_POS1, A_SIG1, A_SPD1, A_POS2, A_SIG2,
    A_SPD2, A_MAXSPD, A_FINISH1};
  localparam logic [31:0] RE [11] = '{32'h1, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h7FFF_FFFF, 32'h3F};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp, motion_mode = 2'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic signed [31:0] goal = 32'h0, measured_position, commanded_position;
  logic signed [31:0] point_move_target_speed, velocity_mode_speed, speed_setpoint;
  logic trigger_out, speed_update;
  logic lt = 1'b0;
  int n_errors = 0, checks_done = 0, cyc = 0;
  int tq[$];
  logic [31:0] sq[$];
  always #4 aclk = ~aclk;
  plt_top #(.SPACING_CYC(SP)) plt_top_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .motion_mode, .measured_position, .commanded_position, .point_move_target_speed,
    .velocity_mode_speed, .trigger_out, .speed_setpoint, .speed_update);
  plt_motion_model #(.TGT_SPEED(TGT), .VEL_SPEED(VSP)) plt_motion_model_inst (
    .aclk, .aresetn, .goal, .measured_position, .commanded_position,
    .point_move_target_speed, .velocity_mode_speed);
  // watchdog and logs of trigger changes and setpoint loads
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (aresetn && trigger_out !== lt) tq.push_back(cyc);
    if (aresetn && speed_update === 1'b1) sq.push_back(speed_setpoint);
    lt <= trigger_out;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask
  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    resp = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  // one entry: index, position, then level or speed at offset k
  task automatic ent(input logic [7:0] b, input logic [5:0] i, input logic [31:0] p, input logic [7:0] k,
    input logic [31:0] v);
    wr(A_EIDX, {26'h0, i});
    wr(b, p);
    wr(b + k, v);
  endtask
  task automatic go(input int g);
    goal <= g;
    do @(posedge aclk); while (measured_position !== g);
    repeat (2 * SP) @(posedge aclk);
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (RA[i]) begin
      rd(RA[i], rv);
      chk(rv, RE[i]);
    end
    rd(8'hF0, rv);
    chk(rv, 32'h0);
    chk(resp, RESP_SLVERR);
    wr(8'hF0, 32'h0);
    chk(resp, RESP_SLVERR);
    wr(A_KIND2, 32'h2);
    wr(A_KIND2, 32'h3);
    chk(resp, RESP_OKAY);
    rd(A_KIND2, rv);
    chk(rv, 32'h2);
    ent(A_POS1, 6'h0, 32'h0, 8'h04, 32'h2);
    rd(A_SIG1, rv);
    chk(rv, 32'h0);
    $display("test registers done");
    // entries closer than the spacing on purpose; entry 4 past the finish
    wr(A_IDLE, 32'h1);
    ent(A_POS1, 6'h1, 32'h1E, 8'h04, 32'h0);
    ent(A_POS1, 6'h2, 32'h23, 8'h04, 32'h1);
    ent(A_POS1, 6'h3, 32'h3C, 8'h04, 32'h0);
    ent(A_POS1, 6'h4, 32'h50, 8'h04, 32'h1);
    wr(A_START1, 32'h1);
    wr(A_FINISH1, 32'h3);
    tq.delete();
    wr(A_ACTIVE, 32'h1);
    chk(trigger_out, 1'b1);
    go(32'h64);
    chk(tq.size(), 32'h4);
    chk(tq[2] - tq[1] >= SP, 1'b1);
    chk(tq[3] - tq[2] >= SP, 1'b1);
    chk(trigger_out, 1'b0);
    rd(A_STATUS, rv);
    chk({rv[14], rv[1]}, 2'h2);
    rd(A_START1, rv);
    chk(rv, 32'h1);
    $display("test signal list done");
    wr(A_MAXSPD, 32'h3E8);
    ent(A_POS2, 6'h0, 32'h78, 8'h08, 32'h0);
    ent(A_POS2, 6'h1, 32'h82, 8'h08, 32'h1F4);
    ent(A_POS2, 6'h2, 32'h8C, 8'h08, 32'hFFFF_EC78);
    wr(A_FINISH2, 32'h2);
    motion_mode <= MODE_PTP;
    sq.delete();
    wr(A_ACTIVE, 32'h2);
    go(32'hA0);
    chk(sq.size(), 32'h3);
    chk(sq[0], TGT);
    chk(sq[1], 32'h1F4);
    chk(sq[2], 32'hFFFF_FC18);
    // velocity mode, travel back past entry 1 before entry 0 matches
    motion_mode <= MODE_VEL;
    wr(A_FINISH2, 32'h1);
    sq.delete();
    wr(A_ACTIVE, 32'h2);
    go(32'h6E);
    go(32'hA0);
    chk(sq.size(), 32'h2);
    chk(sq[0], 32'h0);
    chk(sq[1], VSP);
    wr(A_IDLE, 32'h0);
    wr(A_ACTIVE, 32'h0);
    chk(trigger_out, 1'b0);
    $display("test speed list done");
    results();
  end
endmodule
